//--- hdl/sslin_map.svh
// constants of the speed scaling and linearization block
`ifndef SSLIN_MAP_SVH
`define SSLIN_MAP_SVH

// core clock and the 10 ms setting unit
`define SSLIN_CLK_HZ        32'h0EE6_B280
`define SSLIN_CLK_PERIOD_NS 32'h0000_0004
`define SSLIN_TICK_NS       32'h0098_9680
`define SSLIN_TICK_CYC      (`SSLIN_TICK_NS / `SSLIN_CLK_PERIOD_NS)

// curve points: thousandths of a percent, full scale and reset value
`define SSLIN_PT_FULL       18'h186A0
`define SSLIN_PT_RESET      18'h186A0
`define SSLIN_PT_COUNT      16
`define SSLIN_PT_CODE_LAST  5'h1F

// scaling factors
`define SSLIN_MILLI         16'h03E8
`define SSLIN_SEC_PER_MIN   16'h003C

// display refresh in 10 ms ticks
`define SSLIN_UPD_MIN       7'h05
`define SSLIN_UPD_MAX       7'h64
`define SSLIN_UPD_DEF       7'h0A

`endif

//--- hdl/sslin_pkg.sv
// types of the speed scaling and linearization block
package sslin_pkg;

   typedef logic signed [17:0] sslin_pct_t;
   typedef logic signed [39:0] sslin_val_t;

   typedef enum logic [2:0] {
      SSLIN_DISP_HZ,
      SSLIN_DISP_KHZ,
      SSLIN_DISP_TPS,
      SSLIN_DISP_TPM,
      SSLIN_DISP_CUSTOM
   } sslin_disp_t;

   typedef enum logic [1:0] {
      SSLIN_LIN_OFF,
      SSLIN_LIN_MIRROR,
      SSLIN_LIN_FULL
   } sslin_lin_t;

   typedef enum logic [2:0] {
      SSLIN_TRIG_OFF,
      SSLIN_TRIG_UNDER,
      SSLIN_TRIG_OVER,
      SSLIN_TRIG_STILL,
      SSLIN_TRIG_FWD_OVER
   } sslin_trig_t;

   typedef enum {
      SSLIN_SQ_FREQ,
      SSLIN_SQ_SCALE,
      SSLIN_SQ_PCT,
      SSLIN_SQ_INTERP
   } sslin_seq_t;

endpackage

//--- hdl/sslin_div_if.sv
// carrier between the sequencer and the shared divider
`timescale 1ns/1ps
interface sslin_div_if #(parameter int DW = 56);
   logic          start;
   logic [DW-1:0] dividend;
   logic [DW-1:0] divisor;
   logic          busy;
   logic          done;
   logic [DW-1:0] quotient;

   modport master (output start, output dividend, output divisor,
                   input busy, input done, input quotient);
   modport slave  (input start, input dividend, input divisor,
                   output busy, output done, output quotient);
endinterface

//--- hdl/sslin_divider.sv
// shared unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
module sslin_divider
   import sslin_pkg::*;
#(
   parameter int DW = 56
)(
   input  wire logic core_clk,  // core clock
   input  wire logic rst_n,     // async reset, active low
   input  wire logic clk_en,    // freezes all state while low
   sslin_div_if.slave div       // request and answer
);

   logic [DW-1:0] rem_r;
   logic [DW-1:0] rem_nxt;
   logic [DW-1:0] quo_r;
   logic [DW-1:0] quo_nxt;
   logic [DW-1:0] dvs_r;
   logic [DW-1:0] dvs_nxt;
   logic [6:0]    cnt_r;
   logic [6:0]    cnt_nxt;
   logic          busy_r;
   logic          busy_nxt;
   logic          done_r;
   logic          done_nxt;

   if (DW < 8 || DW > 127)
      $error("sslin_divider: DW out of range");

   always_comb
   begin
      logic [DW:0] trial;
      trial    = '0;
      rem_nxt  = rem_r;
      quo_nxt  = quo_r;
      dvs_nxt  = dvs_r;
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (div.start && !busy_r)
      begin
         rem_nxt = '0;
         // divisor held so a source that moves cannot spoil a running divide
         dvs_nxt = div.divisor;
         cnt_nxt = 7'(DW);
         // a zero divisor answers zero at once instead of all ones
         if (div.divisor == '0)
         begin
            quo_nxt  = '0;
            done_nxt = 1'b1;
         end
         else
         begin
            quo_nxt  = div.dividend;
            busy_nxt = 1'b1;
         end
      end
      else if (busy_r)
      begin
         trial = {rem_r, quo_r[DW-1]};
         if (trial >= {1'b0, dvs_r})
         begin
            trial   = trial - {1'b0, dvs_r};
            quo_nxt = {quo_r[DW-2:0], 1'b1};
         end
         else
            quo_nxt = {quo_r[DW-2:0], 1'b0};
         rem_nxt = trial[DW-1:0];
         cnt_nxt = cnt_r - 7'h01;
         if (cnt_r == 7'h01)
         begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rem_r  <= '0;
         quo_r  <= '0;
         dvs_r  <= '0;
         cnt_r  <= 7'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else if (clk_en)
      begin
         rem_r  <= rem_nxt;
         quo_r  <= quo_nxt;
         dvs_r  <= dvs_nxt;
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign div.busy     = busy_r;
   assign div.done     = done_r;
   assign div.quotient = quo_r;

endmodule

//--- hdl/sslin_top.sv
// speed scaling, curve linearization, zero/standstill timing and relays
`timescale 1ns/1ps
`include "sslin_map.svh"
module sslin_top
   import sslin_pkg::*;
#(
   parameter int TICK_CYC = `SSLIN_TICK_CYC,
   parameter int DW       = 56
)(
   input  wire logic        core_clk,          // 250 MHz core clock
   input  wire logic        rst_n,             // async reset, active low
   input  wire logic        clk_en,            // freezes all state while low
   input  wire logic        enc_a_pin,         // encoder channel A
   input  wire logic        enc_b_pin,         // encoder channel B
   input  wire logic        remote_input_one,  // catch release pin, static high
   input  wire logic        key_release,       // release key pulse
   input  wire logic        enc_quad,          // 1: A/B quadrature input
   input  wire logic        pt_wr,             // curve point write strobe
   input  wire logic [4:0]  pt_code,           // point code index
   input  wire sslin_pct_t  pt_data,           // point value, 0.001 %
   input  wire sslin_lin_t  lin_mode,          // linearization mode
   input  wire sslin_val_t  full_scale,        // 100 % in measured units
   input  wire logic [6:0]  update_time,       // refresh, 10 ms units, 0=def
   input  wire sslin_disp_t disp_mode,         // engineering units
   input  wire logic [16:0] enc_factor,        // pulses per revolution
   input  wire logic [7:0]  multiplier,        // impulse multiplier
   input  wire logic [13:0] wait_time,         // zero wait, 10 ms units
   input  wire logic [13:0] still_time,        // standstill, 10 ms units
   input  wire sslin_trig_t trig_sel [3],      // trigger_condition_select
   input  wire sslin_val_t  switch_pt [3],     // switching points
   input  wire logic [15:0] pulse_time [3],    // relay pulse, 10 ms units
   input  wire logic [3:0]  catch_assign,      // relay mask, bit3 auto
   input  wire logic [2:0]  out_polarity,      // relay inversion mask
   output logic [39:0]      freq_mhz,          // input frequency, mHz
   output sslin_val_t       disp_value,        // display value, milli-units
   output logic             disp_strobe,       // display refresh pulse
   output sslin_pct_t       lin_value,         // linearized value, 0.001 %
   output logic             zero_freq,         // no pulse within wait time
   output logic             standstill,        // standstill reached
   output logic             dir_reverse,       // reverse rotation
   output logic [2:0]       relay_out          // relay coils
);

   if (TICK_CYC < 1 || DW < 56)
      $error("sslin_top: TICK_CYC or DW cannot be served");

   localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

   function automatic logic [DW-1:0] mag(input sslin_val_t v);
      mag = DW'(v[39] ? -v : v);
   endfunction

   sslin_div_if #(.DW(DW)) div_bus ();

   sslin_divider #(.DW(DW)) u_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .div      (div_bus.slave)
   );

   // input synchronisers: stage 1 feeds only stage 2
   logic [2:0] sync1_r;
   logic [2:0] sync1_nxt;
   logic [2:0] sync2_r;
   logic [2:0] sync2_nxt;

   always_comb
   begin
      sync1_nxt = {remote_input_one, enc_b_pin, enc_a_pin};
      sync2_nxt = sync1_r;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end
      else if (clk_en)
      begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
      end
   end

   // curve points, even code = original, odd code = substitute
   sslin_pct_t pts_r   [32];
   sslin_pct_t pts_nxt [32];

   always_comb
   begin
      pts_nxt = pts_r;
      if (pt_wr)
      begin
         if (pt_data > $signed(`SSLIN_PT_FULL))
            pts_nxt[pt_code] = `SSLIN_PT_FULL;
         else if (pt_data < -$signed(`SSLIN_PT_FULL))
            pts_nxt[pt_code] = -$signed(`SSLIN_PT_FULL);
         else
            pts_nxt[pt_code] = pt_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pts_r <= '{default: `SSLIN_PT_RESET};
      else if (clk_en)
         pts_r <= pts_nxt;
   end

   // period measurement, 10 ms ticks, zero and standstill timing
   logic [31:0] tick_cnt_r, tick_cnt_nxt;
   logic [31:0] per_cnt_r, per_cnt_nxt;
   logic [31:0] period_r, period_nxt;
   logic [13:0] wait_cnt_r, wait_cnt_nxt;
   logic [13:0] still_cnt_r, still_cnt_nxt;
   logic        a_prev_r, a_prev_nxt;
   logic        zero_r, zero_nxt;
   logic        still_r, still_nxt;
   logic        rev_r, rev_nxt;
   logic        tick;
   logic        a_rise;

   assign tick   = (tick_cnt_r == TICK_LAST);
   assign a_rise = sync2_r[0] & ~a_prev_r;

   always_comb
   begin
      tick_cnt_nxt  = tick ? 32'h0 : tick_cnt_r + 32'h1;
      per_cnt_nxt   = (per_cnt_r == 32'hFFFF_FFFF) ? per_cnt_r : per_cnt_r + 32'h1;
      period_nxt    = period_r;
      wait_cnt_nxt  = wait_cnt_r;
      still_cnt_nxt = still_cnt_r;
      a_prev_nxt    = sync2_r[0];
      zero_nxt      = zero_r;
      still_nxt     = still_r;
      rev_nxt       = rev_r;
      if (a_rise)
      begin
         period_nxt    = per_cnt_r + 32'h1;
         per_cnt_nxt   = 32'h0;
         wait_cnt_nxt  = 14'h0;
         still_cnt_nxt = 14'h0;
         zero_nxt      = 1'b0;
         still_nxt     = 1'b0;
         rev_nxt       = enc_quad & sync2_r[1];
      end
      else if (tick)
      begin
         if (wait_cnt_r != 14'h3FFF)
            wait_cnt_nxt = wait_cnt_r + 14'h1;
         if (wait_cnt_nxt >= wait_time)
            zero_nxt = 1'b1;
         if (zero_r && still_cnt_r != 14'h3FFF)
            still_cnt_nxt = still_cnt_r + 14'h1;
         if (zero_r && still_cnt_nxt >= still_time)
            still_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt_r  <= 32'h0;
         per_cnt_r   <= 32'h0;
         period_r    <= 32'h0;
         wait_cnt_r  <= 14'h0;
         still_cnt_r <= 14'h0;
         a_prev_r    <= 1'b0;
         zero_r      <= 1'b1;
         still_r     <= 1'b0;
         rev_r       <= 1'b0;
      end
      else if (clk_en)
      begin
         tick_cnt_r  <= tick_cnt_nxt;
         per_cnt_r   <= per_cnt_nxt;
         period_r    <= period_nxt;
         wait_cnt_r  <= wait_cnt_nxt;
         still_cnt_r <= still_cnt_nxt;
         a_prev_r    <= a_prev_nxt;
         zero_r      <= zero_nxt;
         still_r     <= still_nxt;
         rev_r       <= rev_nxt;
      end
   end

   // sequencer: frequency, scaling, percent, interpolation via one divider
   sslin_seq_t    seq_r, seq_nxt;
   logic          issued_r, issued_nxt;
   logic [DW-1:0] f_r, f_nxt;
   logic [DW-1:0] scaled_r, scaled_nxt;
   sslin_pct_t    pct_r, pct_nxt;
   sslin_pct_t    lin_r, lin_nxt;
   logic [DW-1:0] dvd;
   logic [DW-1:0] dvs;
   logic [3:0]    seg;
   logic [DW-1:0] sw_mag;
   sslin_pct_t    x_in;
   logic signed [18:0] dx, dy, xo;
   logic [16:0]   ppr;
   logic [7:0]    mul;

   assign ppr = (enc_factor == 17'h0) ? 17'h1 : enc_factor;
   assign mul = (multiplier == 8'h0) ? 8'h1 : multiplier;
   // kHz and Hz compare and scale in mHz; modes 2-4 use display units
   assign sw_mag = (disp_mode == SSLIN_DISP_HZ || disp_mode == SSLIN_DISP_KHZ)
                   ? f_r : scaled_r;
   assign x_in = (lin_mode == SSLIN_LIN_MIRROR || !rev_r) ? pct_r : -pct_r;

   always_comb
   begin
      seg = 4'h0;
      for (int i = 1; i < `SSLIN_PT_COUNT - 1; i++)
         if (x_in >= pts_r[2*i])
            seg = 4'(i);
      dx = 19'(pts_r[2*seg+2]) - 19'(pts_r[2*seg]);
      dy = 19'(pts_r[2*seg+3]) - 19'(pts_r[2*seg+1]);
      xo = 19'(x_in) - 19'(pts_r[2*seg]);
      if (xo < 0)
         xo = '0;
      else if (xo > dx)
         xo = dx;
   end

   always_comb
   begin
      dvd = '0;
      dvs = '0;
      unique case (seq_r)
         SSLIN_SQ_FREQ:
         begin
            dvd = DW'(`SSLIN_CLK_HZ) * DW'(`SSLIN_MILLI);
            dvs = DW'(period_r);
         end
         SSLIN_SQ_SCALE:
         begin
            dvs = DW'(ppr);
            case (disp_mode)
               SSLIN_DISP_KHZ:    begin dvd = f_r; dvs = DW'(`SSLIN_MILLI); end
               SSLIN_DISP_TPS:    dvd = f_r;
               SSLIN_DISP_TPM:    dvd = f_r * DW'(`SSLIN_SEC_PER_MIN);
               SSLIN_DISP_CUSTOM: dvd = f_r * DW'(mul);
               default:           begin dvd = f_r; dvs = DW'(1); end
            endcase
         end
         SSLIN_SQ_PCT:
         begin
            dvd = sw_mag * DW'(`SSLIN_PT_FULL);
            dvs = mag(full_scale);
         end
         SSLIN_SQ_INTERP:
         begin
            dvd = DW'(dy < 0 ? -dy : dy) * DW'(xo);
            dvs = DW'(dx);
         end
      endcase
   end

   assign div_bus.start    = !issued_r;
   assign div_bus.dividend = dvd;
   assign div_bus.divisor  = dvs;

   always_comb
   begin
      sslin_pct_t y;
      y          = '0;
      seq_nxt    = seq_r;
      issued_nxt = issued_r;
      // frequency reads zero on the same edge as the zero flag rises
      f_nxt      = zero_nxt ? '0 : f_r;
      scaled_nxt = scaled_r;
      pct_nxt    = pct_r;
      lin_nxt    = lin_r;
      if (!issued_r && !div_bus.busy)
         issued_nxt = 1'b1;
      if (issued_r && div_bus.done)
      begin
         issued_nxt = 1'b0;
         unique case (seq_r)
            SSLIN_SQ_FREQ:
            begin
               f_nxt   = zero_nxt ? '0 : div_bus.quotient;
               seq_nxt = SSLIN_SQ_SCALE;
            end
            SSLIN_SQ_SCALE:
            begin
               scaled_nxt = div_bus.quotient;
               seq_nxt    = SSLIN_SQ_PCT;
            end
            SSLIN_SQ_PCT:
            begin
               pct_nxt = (div_bus.quotient > DW'(`SSLIN_PT_FULL)) ? `SSLIN_PT_FULL
                         : 18'(div_bus.quotient);
               seq_nxt = SSLIN_SQ_INTERP;
            end
            SSLIN_SQ_INTERP:
            begin
               y = pts_r[2*seg+1] + (dy < 0 ? -18'(div_bus.quotient)
                                            : 18'(div_bus.quotient));
               if (lin_mode == SSLIN_LIN_OFF)
                  lin_nxt = x_in;
               else if (lin_mode == SSLIN_LIN_MIRROR && rev_r)
                  lin_nxt = -y;
               else
                  lin_nxt = y;
               seq_nxt = SSLIN_SQ_FREQ;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seq_r    <= SSLIN_SQ_FREQ;
         issued_r <= 1'b0;
         f_r      <= '0;
         scaled_r <= '0;
         pct_r    <= '0;
         lin_r    <= '0;
      end
      else if (clk_en)
      begin
         seq_r    <= seq_nxt;
         issued_r <= issued_nxt;
         f_r      <= f_nxt;
         scaled_r <= scaled_nxt;
         pct_r    <= pct_nxt;
         lin_r    <= lin_nxt;
      end
   end

   // display refresh and relays
   logic [6:0]  upd_cnt_r, upd_cnt_nxt;
   sslin_val_t  disp_r, disp_nxt;
   logic        strobe_r, strobe_nxt;
   logic [2:0]  cond_prev_r, cond_prev_nxt;
   logic [15:0] pulse_cnt_r [3];
   logic [15:0] pulse_cnt_nxt [3];
   logic [2:0]  catch_r, catch_nxt;
   logic [2:0]  relay_r, relay_nxt;
   logic [6:0]  upd_lim;
   sslin_val_t  sw_val;

   assign upd_lim = (update_time == 7'h0) ? `SSLIN_UPD_DEF
                  : (update_time < `SSLIN_UPD_MIN) ? `SSLIN_UPD_MIN
                  : (update_time > `SSLIN_UPD_MAX) ? `SSLIN_UPD_MAX : update_time;
   assign sw_val  = rev_r ? -40'(sw_mag) : 40'(sw_mag);

   always_comb
   begin
      logic [2:0] cond;
      logic [2:0] active;
      logic       release_all;
      cond          = 3'h0;
      active        = 3'h0;
      release_all   = key_release | sync2_r[2];
      upd_cnt_nxt   = upd_cnt_r;
      disp_nxt      = disp_r;
      strobe_nxt    = 1'b0;
      pulse_cnt_nxt = pulse_cnt_r;
      if (tick)
      begin
         upd_cnt_nxt = upd_cnt_r + 7'h01;
         if (upd_cnt_nxt >= upd_lim)
         begin
            upd_cnt_nxt = 7'h00;
            disp_nxt    = rev_r ? -40'(scaled_r) : 40'(scaled_r);
            strobe_nxt  = 1'b1;
         end
      end
      for (int r = 0; r < 3; r++)
      begin
         case (trig_sel[r])
            SSLIN_TRIG_UNDER:    cond[r] = sw_mag < mag(switch_pt[r]);
            SSLIN_TRIG_OVER:     cond[r] = sw_mag > mag(switch_pt[r]);
            SSLIN_TRIG_STILL:    cond[r] = still_r;
            SSLIN_TRIG_FWD_OVER: cond[r] = !rev_r && sw_val > switch_pt[r];
            default:             cond[r] = 1'b0;
         endcase
         if (cond[r] && !cond_prev_r[r])
            pulse_cnt_nxt[r] = pulse_time[r];
         else if (tick && pulse_cnt_r[r] != 16'h0)
            pulse_cnt_nxt[r] = pulse_cnt_r[r] - 16'h1;
         active[r] = (pulse_time[r] == 16'h0) ? cond[r]
                                              : (pulse_cnt_r[r] != 16'h0);
      end
      cond_prev_nxt = cond;
      // a new catch event wins over a release in the same cycle
      catch_nxt = (active & catch_assign[2:0])
                | (catch_r & ~{3{release_all | (catch_assign[3] & still_r)}});
      relay_nxt = (active | catch_r) ^ out_polarity;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         upd_cnt_r   <= 7'h00;
         disp_r      <= '0;
         strobe_r    <= 1'b0;
         cond_prev_r <= 3'h0;
         pulse_cnt_r <= '{default: 16'h0};
         catch_r     <= 3'h0;
         relay_r     <= 3'h0;
      end
      else if (clk_en)
      begin
         upd_cnt_r   <= upd_cnt_nxt;
         disp_r      <= disp_nxt;
         strobe_r    <= strobe_nxt;
         cond_prev_r <= cond_prev_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
         catch_r     <= catch_nxt;
         relay_r     <= relay_nxt;
      end
   end

   assign freq_mhz    = f_r[39:0];
   assign disp_value  = disp_r;
   assign disp_strobe = strobe_r;
   assign lin_value   = lin_r;
   assign zero_freq   = zero_r;
   assign standstill  = still_r;
   assign dir_reverse = rev_r;
   assign relay_out   = relay_r;

endmodule

//--- sim/sslin_enc_model.sv
// quadrature encoder source for the speed block pins
`timescale 1ns/1ps
module sslin_enc_model #(
   parameter int PER = 100
)(
   input  wire logic core_clk, // clock
   input  wire logic run,      // turn while high
   input  wire logic rev,      // reverse turn
   output logic      enc_a,    // channel a
   output logic      enc_b     // channel b
);
   int ph_r = 0;
   always @(posedge core_clk)
      if (run)
         ph_r <= (ph_r + 1) % PER;
   assign enc_a = ph_r < PER / 2;
   // b lags a going forward and leads it in reverse, so b at a rise gives the way
   assign enc_b = rev ? ((ph_r + PER / 4) % PER) < PER / 2
                      : (ph_r >= PER / 4 && ph_r < 3 * PER / 4);
endmodule

//--- sim/sslin_checker.sv
// port assertions of the speed block
`timescale 1ns/1ps
module sslin_checker
   import sslin_pkg::*;
(
   input wire logic        core_clk,      // clk
   input wire logic        rst_n,         // rst
   input wire logic        enc_quad,      // quad
   input wire sslin_trig_t trig_sel [3],  // trig
   input wire logic [15:0] pulse_time [3],// pulse
   input wire logic [3:0]  catch_assign,  // catch
   input wire logic [2:0]  out_polarity,  // pol
   input wire logic [39:0] freq_mhz,      // freq
   input wire sslin_val_t  disp_value,    // disp
   input wire logic        disp_strobe,   // strobe
   input wire logic        zero_freq,     // zero
   input wire logic        standstill,    // still
   input wire logic        dir_reverse,   // rev
   input wire logic [2:0]  relay_out      // relays
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   zero_no_freq_a: assert property (zero_freq |-> freq_mhz == 40'h0000000000)
      else $error("freq not zero");
   still_zero_a: assert property (standstill |-> zero_freq)
      else $error("still without zero");
   still_clear_a: assert property ($fell(zero_freq) |-> !standstill)
      else $error("still kept");
   strobe_single_a: assert property (disp_strobe |=> !disp_strobe)
      else $error("long strobe");
   disp_hold_a: assert property (!disp_strobe |-> $stable(disp_value))
      else $error("display moved");
   relay_still_a: assert property (trig_sel[0] == SSLIN_TRIG_STILL && !catch_assign[0]
         && pulse_time[0] == 16'h0000 && !out_polarity[0] |-> relay_out[0] == $past(standstill))
      else $error("still relay wrong");
   relay_pol_a: assert property (trig_sel[1] == SSLIN_TRIG_OFF && !catch_assign[1]
         |=> relay_out[1] == $past(out_polarity[1]))
      else $error("idle relay wrong");
   dir_quad_a: assert property ($rose(dir_reverse) |-> $past(enc_quad))
      else $error("reverse without quad");
endmodule
bind sslin_top sslin_checker chk (.core_clk(core_clk), .rst_n(rst_n), .enc_quad(enc_quad),
   .trig_sel(trig_sel), .pulse_time(pulse_time), .catch_assign(catch_assign),
   .out_polarity(out_polarity), .freq_mhz(freq_mhz), .disp_value(disp_value),
   .disp_strobe(disp_strobe), .zero_freq(zero_freq), .standstill(standstill),
   .dir_reverse(dir_reverse), .relay_out(relay_out));

//--- sim/sslin_top_bench.sv
// self-checking bench of the speed block
`timescale 1ns/1ps
`include "sslin_map.svh"
module sslin_top_bench;
   import sslin_pkg::*;
   localparam int TICK = 20;
   logic        core_clk = 1'b0, rst_n = 1'b0, run = 1'b0, rev = 1'b0, enc_a, enc_b;
   logic        remote_input_one = 1'b0, enc_quad = 1'b1;
   logic        key_release = 1'b0, pt_wr = 1'b0, disp_strobe, zero_freq, standstill, dir_reverse;
   logic [4:0]  pt_code = 5'h00;
   logic [6:0]  update_time = 7'h05;
   logic [2:0]  out_polarity = 3'h2, relay_out;
   logic [3:0]  catch_assign = 4'h4;
   logic [7:0]  multiplier = 8'h03;
   logic [16:0] enc_factor = 17'h00020;
   logic [39:0] freq_mhz;
   logic [15:0] pulse_time [3] = '{16'h0000, 16'h0008, 16'h0000};
   sslin_pct_t  pt_data = 18'h00000, lin_value;
   sslin_lin_t  lin_mode = SSLIN_LIN_FULL;
   sslin_disp_t disp_mode = SSLIN_DISP_HZ;
   sslin_val_t  full_scale = 40'h01DCD65000, disp_value;
   sslin_val_t  switch_pt [3] = '{40'h003B9ACA00, 40'h003B9ACA00, 40'h00B2D05E00};
   sslin_trig_t trig_sel [3] = '{SSLIN_TRIG_STILL, SSLIN_TRIG_OFF, SSLIN_TRIG_FWD_OVER};
   int          fail_count = 0, checks = 0, pulse_cnt = 0, n;
   sslin_enc_model enc (.core_clk(core_clk), .run(run), .rev(rev), .enc_a(enc_a), .enc_b(enc_b));
   sslin_top #(.TICK_CYC(TICK), .DW(56)) dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
      .enc_a_pin(enc_a), .enc_b_pin(enc_b), .remote_input_one(remote_input_one),
      .key_release(key_release), .enc_quad(enc_quad), .pt_wr(pt_wr), .pt_code(pt_code),
      .pt_data(pt_data), .lin_mode(lin_mode),
      .full_scale(full_scale), .update_time(update_time), .disp_mode(disp_mode),
      .enc_factor(enc_factor), .multiplier(multiplier), .wait_time(14'h0014),
      .still_time(14'h000A), .trig_sel(trig_sel), .switch_pt(switch_pt),
      .pulse_time(pulse_time), .catch_assign(catch_assign), .out_polarity(out_polarity),
      .freq_mhz(freq_mhz), .disp_value(disp_value), .disp_strobe(disp_strobe),
      .lin_value(lin_value), .zero_freq(zero_freq), .standstill(standstill),
      .dir_reverse(dir_reverse), .relay_out(relay_out));
   always #2 core_clk = ~core_clk;
   always @(negedge core_clk)
      if (relay_out[1] === 1'b1)
         pulse_cnt++;
   task automatic check(input logic signed [39:0] seen, exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   // every wait_hi wait is bounded so a dead output ends the run instead of hanging it
   task automatic wait_hi(input int sel, input int lim);
      n = 0;
      while ((sel == 0 ? zero_freq : sel == 1 ? standstill : disp_strobe) !== 1'b1)
      begin
         cyc(1);
         n++;
         if (n > lim)
         begin
            fail_count++;
            end_of_test();
         end
      end
   endtask
   task automatic t_reset;
      check(zero_freq, 1'b1, "zero");
      check(relay_out, 3'h0, "relays");
      @(posedge core_clk);
      rst_n <= 1'b1;
   endtask
   task automatic t_curve;
      int x;
      for (int k = 0; k < 32; k++)
      begin
         // the last two points (codes 30 and 31) are written out of range to see them clamp: code 30 over, code 31 wraps negative
         x = (k > 29) ? 18'h1FFFF : (k / 2) * 18'h030D4 - `SSLIN_PT_FULL;
         if (k % 4 == 3)
            x = x + `SSLIN_MILLI;
         @(posedge core_clk);
         pt_wr <= 1'b1;
         pt_code <= k[4:0];
         pt_data <= x[17:0];
      end
      @(posedge core_clk);
      pt_wr <= 1'b0;
      run <= 1'b1;
      cyc(2000);
      check(freq_mhz, 40'h009502F900, "freq");
      check(lin_value, 18'sh07C06, "lin full");
      check(relay_out, 3'h2, "idle relays");
      @(posedge core_clk);
      lin_mode <= SSLIN_LIN_MIRROR;
      rev <= 1'b1;
      cyc(2000);
      check(dir_reverse, 1'b1, "reverse");
      check(disp_value, -40'sh009502F900, "rev disp");
      check(lin_value, -18'sh07C06, "lin mirror");
      @(posedge core_clk);
      lin_mode <= SSLIN_LIN_FULL;
      disp_mode <= SSLIN_DISP_TPM;
      cyc(1500);
      // curve now runs on the turns-per-minute value, 58593 thousandths
      check(lin_value, -18'sh0E232, "lin signed");
      check(relay_out[2], 1'b0, "rev over");
      @(posedge core_clk);
      disp_mode <= SSLIN_DISP_HZ;
      // pins keep turning backwards: with quadrature off it must read forward
      enc_quad <= 1'b0;
   endtask
   task automatic t_display;
      sslin_val_t exp [5] = '{40'h009502F900, 40'h00002625A0, 40'h0004A817C8,
                              40'h01176592E0, 40'h000DF84758};
      @(posedge core_clk);
      out_polarity <= 3'h0;
      trig_sel[1] <= SSLIN_TRIG_UNDER;
      for (int m = 0; m < 5; m++)
      begin
         @(posedge core_clk);
         disp_mode <= sslin_disp_t'(m);
         cyc(1500);
         check(disp_value, exp[m], "disp");
         check(relay_out[2], m > 2, "over");
      end
      @(posedge core_clk);
      remote_input_one <= 1'b1;
      cyc(6);
      check(relay_out[2], 1'b0, "remote release");
      @(posedge core_clk);
      remote_input_one <= 1'b0;
      disp_mode <= SSLIN_DISP_TPM;
      cyc(1500);
      check(relay_out[2], 1'b1, "catch again");
      @(posedge core_clk);
      key_release <= 1'b1;
      disp_mode <= SSLIN_DISP_HZ;
      @(posedge core_clk);
      key_release <= 1'b0;
      cyc(4);
      check(relay_out[2], 1'b0, "release");
      check(dir_reverse, 1'b0, "quad off");
   endtask
   task automatic t_refresh;
      for (int u = 0; u < 2; u++)
      begin
         @(posedge core_clk);
         update_time <= u ? 7'h00 : 7'h05;
         cyc(500);
         wait_hi(2, 300);
         cyc(1);
         wait_hi(2, 300);
         check(n + 1, TICK * (u ? `SSLIN_UPD_DEF : `SSLIN_UPD_MIN), "refresh");
      end
   endtask
   task automatic t_stop;
      @(posedge core_clk);
      disp_mode <= SSLIN_DISP_HZ;
      cyc(1500);
      pulse_cnt = 0;
      @(posedge enc_a);
      run <= 1'b0;
      wait_hi(0, 460);
      check(n > 370 && n < 430, 1'b1, "zero time");
      wait_hi(1, 260);
      check(n > 175 && n < 225, 1'b1, "still time");
      cyc(2);
      check(relay_out[0], 1'b1, "still relay");
      check(pulse_cnt > 135 && pulse_cnt < 185, 1'b1, "pulse");
   endtask
   initial
   begin
      cyc(3);
      t_reset();
      t_curve();
      t_display();
      t_refresh();
      t_stop();
      end_of_test();
   end
endmodule
